/* File: hw/bcl_regs.vh */
// constants for the boot code loader: strap fields, encodings, timing
// assumes a 250 MHz system clock (4 ns period)
`ifndef BCL_REGS_VH
`define BCL_REGS_VH
`define BCL_CLK_PERIOD_NS 4
`define BCL_STRAP_CLKSEL_LSB 0
`define BCL_STRAP_CLKSEL_MSB 1
`define BCL_STRAP_BOOTSRC 2
`define BCL_CLKSEL_XTAL 2'h0
`define BCL_CLKSEL_FS8K 2'h1
`define BCL_CLKSEL_FS16K 2'h2
`define BCL_CLKSEL_RSVD 2'h3
`define BCL_BOOT_HOST 1'h0
`define BCL_BOOT_FLASH 1'h1
`define BCL_HOST_IF_I2C 1'h0
`define BCL_HOST_IF_SPI 1'h1
`define BCL_SPI_DETECT_EDGES 3'h2
`define BCL_STRAP_SETTLE_NS 3000000
`define BCL_STRAP_SETTLE_CYC (`BCL_STRAP_SETTLE_NS / `BCL_CLK_PERIOD_NS)
`define BCL_BOOT_LIMIT_NS 1000000000
`define BCL_BOOT_LIMIT_CYC (`BCL_BOOT_LIMIT_NS / `BCL_CLK_PERIOD_NS)
`define BCL_FLASH_SCK_DIV 8'h04
`endif

/* File: hw/bcl_sync.v */
// two-flop synchroniser bank for pins from outside the mclk domain
// assumes inputs are asynchronous levels; no logic reads the first stage
`timescale 1ns/1ps
`default_nettype none
module bcl_sync #(
    parameter W = 1
) (
    input wire mclk, // system clock
    input wire rst_n, // async reset, active low
    input wire [W-1:0] d_in, // asynchronous inputs
    output wire [W-1:0] q_out // synchronised inputs
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg s1_q;
            reg s2_q;
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= d_in[i];
                    s2_q <= s1_q;
                end
            end
            assign q_out[i] = s2_q;
        end
    endgenerate
endmodule // bcl_sync
`default_nettype wire

/* File: hw/bcl_boot_loader.v */
// boot code loader: strap sampling, wake-up sequencing, flash fetch,
// host interface detection and boot-master selection.
// assumes analogue regulator/PLL status arrive as async levels.
// Summary of operation
// - code comes from flash or host port
// - boot source taken from strap after reset release and settle
// - image holds firmware then configuration record
// - configuration record sets all user registers
// - hostless system never swaps firmware
// - regulator on after reset if supply strap low
// - PLL enabled only after core supply good
// - PLL source from straps, wait for lock
// - when ready: push event, assert host interrupt
// - auto boot then reads flash
// - host boot: first active interface becomes master
// - two host clock cycles select SPI slave
// - flash boot past one second sets boot_timeout, fetch continues
// - pin nine is flash chip select
// - reset low tristates the flash outputs only
// - strap 0 host boot, 1 flash boot
// - clock straps: crystal, 8k, 16k, reserved
// - after flash load: defaults, then run firmware
`timescale 1ns/1ps
`default_nettype none
`include "bcl_regs.vh"
module bcl_boot_loader #(
    parameter [31:0] STRAP_SETTLE_CYC = `BCL_STRAP_SETTLE_CYC,
    parameter [31:0] BOOT_LIMIT_CYC = `BCL_BOOT_LIMIT_CYC,
    parameter [23:0] IMAGE_BYTES = 24'h000100
) (
    input wire mclk, // system clock 250 MHz
    input wire rst_n, // async reset, active low
    input wire [2:0] boot_straps, // strap pins
    input wire supply_source_strap, // 1 external core supply
    input wire core_supply_good, // core supply established
    input wire pll_locked, // pll lock indication
    input wire swap_req, // firmware swap request, one-cycle pulse
    input wire swap_from_flash, // load mode for swap
    input wire host_clk, // host bus port clock pin
    input wire host_cs_n, // host bus port spi select pin
    input wire host_sda_in, // host bus port i2c data pin
    input wire flash_miso, // flash serial data in
    output reg regulator_en, // internal core regulator enable
    output reg pll_en, // pll enable
    output reg [1:0] pll_src, // pll reference select
    output reg host_interrupt_n, // host interrupt, active low
    output reg event_push, // event queue write, pulse
    output reg host_if_spi, // 1 spi slave, 0 i2c slave
    output reg host_master_valid, // boot master chosen
    output reg flash_chip_select, // flash chip select level (low active)
    output reg flash_chip_select_oe, // flash chip select drive enable
    output reg flash_sck, // flash serial clock
    output reg flash_sck_oe, // flash clock drive enable
    output reg flash_mosi, // flash serial data out
    output reg flash_mosi_oe, // flash data drive enable
    output reg [7:0] load_byte, // byte fetched from flash
    output reg load_byte_valid, // byte strobe, pulse
    output reg load_in_config, // byte belongs to config record
    output reg cfg_defaults, // program config defaults, pulse
    output reg run_firmware, // jump to program ram, level
    output reg boot_timeout // flash boot exceeded limit
);
    localparam [2:0] ST_SETTLE = 3'h0;
    localparam [2:0] ST_SUPPLY = 3'h1;
    localparam [2:0] ST_PLL = 3'h2;
    localparam [2:0] ST_READY = 3'h3;
    localparam [2:0] ST_FLASH = 3'h4;
    localparam [2:0] ST_HOST = 3'h5;
    localparam [2:0] ST_RUN = 3'h6;
    // straps are pins as well, so they pass the synchroniser like the rest
    wire [9:0] sync_out;
    bcl_sync #(.W(10)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d_in({boot_straps, supply_source_strap, core_supply_good, pll_locked, host_clk,
               host_cs_n, host_sda_in, flash_miso}),
        .q_out(sync_out)
    );
    wire [2:0] straps_s = sync_out[9:7];
    wire ext_s = sync_out[6];
    wire supply_s = sync_out[5];
    wire lock_s = sync_out[4];
    wire hclk_s = sync_out[3];
    wire hcs_s = sync_out[2];
    wire hsda_s = sync_out[1];
    wire miso_s = sync_out[0];
    reg [2:0] state_q;
    reg [31:0] cnt_q;
    reg [31:0] boot_cnt_q;
    reg [2:0] straps_q;
    reg flash_mode_q;
    reg hclk_d_q;
    reg hsda_d_q;
    reg [2:0] edge_cnt_q;
    reg if_locked_q;
    reg [7:0] div_q;
    reg [5:0] bit_q;
    reg [23:0] byte_cnt_q;
    reg [7:0] shift_q;
    wire sck_tick = (div_q == `BCL_FLASH_SCK_DIV);
    wire hclk_rise = hclk_s & ~hclk_d_q;
    wire i2c_start = hclk_s & hsda_d_q & ~hsda_s;
    // command byte 0x03 then 24-bit address zero: 32 header bits
    wire [31:0] rd_cmd = 32'h03000000;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_SETTLE;
            cnt_q <= 32'h00000000;
            boot_cnt_q <= 32'h00000000;
            straps_q <= 3'h0;
            flash_mode_q <= 1'b0;
            hclk_d_q <= 1'b0;
            hsda_d_q <= 1'b1;
            edge_cnt_q <= 3'h0;
            if_locked_q <= 1'b0;
            div_q <= 8'h00;
            bit_q <= 6'h00;
            byte_cnt_q <= 24'h000000;
            shift_q <= 8'h00;
            regulator_en <= 1'b0;
            pll_en <= 1'b0;
            pll_src <= `BCL_CLKSEL_XTAL;
            host_interrupt_n <= 1'b1;
            event_push <= 1'b0;
            host_if_spi <= `BCL_HOST_IF_I2C;
            host_master_valid <= 1'b0;
            flash_chip_select <= 1'b1;
            flash_chip_select_oe <= 1'b0;
            flash_sck <= 1'b0;
            flash_sck_oe <= 1'b0;
            flash_mosi <= 1'b0;
            flash_mosi_oe <= 1'b0;
            load_byte <= 8'h00;
            load_byte_valid <= 1'b0;
            load_in_config <= 1'b0;
            cfg_defaults <= 1'b0;
            run_firmware <= 1'b0;
            boot_timeout <= 1'b0;
        end else begin
            event_push <= 1'b0;
            load_byte_valid <= 1'b0;
            cfg_defaults <= 1'b0;
            hclk_d_q <= hclk_s;
            hsda_d_q <= hsda_s;
            // host interface detection runs until latched
            if (!if_locked_q && state_q != ST_SETTLE) begin
                if (hclk_rise && !hcs_s) begin
                    if (edge_cnt_q + 3'h1 >= `BCL_SPI_DETECT_EDGES) begin
                        host_if_spi <= `BCL_HOST_IF_SPI;
                        if_locked_q <= 1'b1;
                    end
                    edge_cnt_q <= edge_cnt_q + 3'h1;
                end else if (i2c_start) begin
                    host_if_spi <= `BCL_HOST_IF_I2C;
                    if_locked_q <= 1'b1;
                end
            end
            case (state_q)
                ST_SETTLE: begin
                    // straps sampled after release, never under reset
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q + 32'h1 >= STRAP_SETTLE_CYC) begin
                        straps_q <= straps_s;
                        flash_mode_q <= straps_s[`BCL_STRAP_BOOTSRC];
                        regulator_en <= ~ext_s;
                        state_q <= ST_SUPPLY;
                    end
                end
                ST_SUPPLY: begin
                    if (supply_s) begin
                        pll_en <= 1'b1;
                        // reserved code falls back to crystal
                        pll_src <= (straps_q[1:0] == `BCL_CLKSEL_RSVD) ? `BCL_CLKSEL_XTAL
                                   : straps_q[1:0];
                        state_q <= ST_PLL;
                    end
                end
                ST_PLL: begin
                    if (lock_s) begin
                        state_q <= ST_READY;
                    end
                end
                ST_READY: begin
                    event_push <= 1'b1;
                    host_interrupt_n <= 1'b0;
                    boot_cnt_q <= 32'h00000000;
                    if (flash_mode_q == `BCL_BOOT_FLASH) begin
                        flash_chip_select_oe <= 1'b1;
                        flash_chip_select <= 1'b0;
                        flash_sck_oe <= 1'b1;
                        flash_mosi_oe <= 1'b1;
                        flash_mosi <= rd_cmd[31];
                        bit_q <= 6'h00;
                        byte_cnt_q <= 24'h000000;
                        div_q <= 8'h00;
                        state_q <= ST_FLASH;
                    end else begin
                        state_q <= ST_HOST;
                    end
                end
                ST_FLASH: begin
                    boot_cnt_q <= boot_cnt_q + 32'h1;
                    if (boot_cnt_q >= BOOT_LIMIT_CYC) begin
                        boot_timeout <= 1'b1;
                    end
                    div_q <= sck_tick ? 8'h00 : div_q + 8'h01;
                    if (sck_tick) begin
                        flash_sck <= ~flash_sck;
                        if (!flash_sck) begin
                            // rising edge: sample data once header is out
                            if (bit_q >= 6'h20) begin
                                shift_q <= {shift_q[6:0], miso_s};
                                if (bit_q == 6'h27) begin
                                    load_byte <= {shift_q[6:0], miso_s};
                                    load_byte_valid <= 1'b1;
                                    // image: firmware first half, config after
                                    load_in_config <= (byte_cnt_q >= (IMAGE_BYTES >> 1));
                                    byte_cnt_q <= byte_cnt_q + 24'h000001;
                                    bit_q <= 6'h20;
                                end else begin
                                    bit_q <= bit_q + 6'h01;
                                end
                            end else begin
                                bit_q <= bit_q + 6'h01;
                            end
                        end else if (bit_q < 6'h20) begin
                            flash_mosi <= rd_cmd[5'h1F - bit_q[4:0]];
                        end
                        if (byte_cnt_q == IMAGE_BYTES) begin
                            flash_chip_select <= 1'b1;
                            flash_sck <= 1'b0;
                            cfg_defaults <= 1'b1;
                            state_q <= ST_RUN;
                        end
                    end
                end
                ST_HOST: begin
                    if (if_locked_q) begin
                        host_master_valid <= 1'b1;
                        host_interrupt_n <= 1'b1;
                    end
                    if (swap_req) begin
                        flash_mode_q <= swap_from_flash;
                        if_locked_q <= 1'b0;
                        edge_cnt_q <= 3'h0;
                        host_master_valid <= 1'b0;
                        state_q <= ST_READY;
                    end
                end
                ST_RUN: begin
                    run_firmware <= 1'b1;
                    host_interrupt_n <= 1'b1;
                    // a swap only arrives from a host; none in hostless systems
                    if (swap_req) begin
                        flash_mode_q <= swap_from_flash;
                        run_firmware <= 1'b0;
                        if_locked_q <= 1'b0;
                        edge_cnt_q <= 3'h0;
                        host_master_valid <= 1'b0;
                        state_q <= ST_READY;
                    end
                end
                default: begin
                    state_q <= ST_SETTLE;
                end
            endcase
        end
    end
endmodule // bcl_boot_loader
`default_nettype wire

/* File: test/bcl_flash_model.sv */
// serial flash stand-in: takes a read command, then sends a byte ramp
// assumes spi mode 0, select active low, no pull on the data line
`timescale 1ns/1ps
`default_nettype none
module bcl_flash_model (
    input wire logic sck, // serial clock
    input wire logic cs_n, // select, active low
    input wire logic mosi, // data from loader
    output logic miso, // data to loader
    output logic [31:0] cmd_word // command and address seen
);
    int bitn;
    logic [7:0] cur;
    initial begin
        miso = 1'b0;
        bitn = 0;
        cmd_word = 32'h00000000;
    end
    // one process per variable; sck rests low whenever select falls
    always @(posedge sck or negedge cs_n) begin
        if (!sck) begin
            bitn = 0;
        end else if (!cs_n) begin
            if (bitn < 32) cmd_word = {cmd_word[30:0], mosi};
            bitn = bitn + 1;
        end
    end
    // released line shows the inverse, never a stale bit
    always @(negedge sck or posedge cs_n) begin
        if (!cs_n && bitn >= 32) begin
            cur = 8'h3C + 8'h11 * 8'((bitn - 32) / 8);
            miso = cur[7 - (bitn - 32) % 8];
        end else begin
            miso = ~miso;
        end
    end
endmodule // bcl_flash_model
`default_nettype wire

/* File: test/bcl_boot_loader_sva.sv */
// port checker for the boot code loader
// assumes a single mclk domain; attached by the bind below
`timescale 1ns/1ps
`default_nettype none
module bcl_boot_loader_sva (
    input wire logic mclk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic [2:0] boot_straps, // straps
    input wire logic supply_source_strap, // supply strap
    input wire logic core_supply_good, // supply pin
    input wire logic swap_req, // swap pulse
    input wire logic regulator_en, // regulator
    input wire logic pll_en, // pll enable
    input wire logic [1:0] pll_src, // pll source
    input wire logic host_interrupt_n, // host irq
    input wire logic event_push, // event strobe
    input wire logic host_if_spi, // interface latch
    input wire logic host_master_valid, // master chosen
    input wire logic flash_chip_select_oe, // select drive
    input wire logic flash_sck_oe, // clock drive
    input wire logic flash_mosi_oe, // data drive
    input wire logic cfg_defaults, // defaults strobe
    input wire logic run_firmware // running
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_RESET_QUIET: assert property ($rose(rst_n) |-> host_interrupt_n &&
        !flash_chip_select_oe && !flash_sck_oe && !flash_mosi_oe) else $error("outputs not idle");
    AST_REG_STRAP: assert property ($rose(regulator_en) |-> !supply_source_strap)
        else $error("regulator with external supply");
    AST_PLL_SUPPLY: assert property ($rose(pll_en) |-> $past(core_supply_good, 2))
        else $error("pll before supply");
    AST_PLL_SRC: assert property (pll_en |-> pll_src ==
        ((boot_straps[1:0] == 2'h3) ? 2'h0 : boot_straps[1:0])) else $error("pll source");
    AST_EVENT_IRQ: assert property ($rose(event_push) |-> ##[0:1] !host_interrupt_n)
        else $error("no irq with event");
    AST_EVENT_PULSE: assert property (event_push |=> !event_push)
        else $error("event longer than a cycle");
    AST_IRQ_RELEASE: assert property ($rose(host_interrupt_n) |->
        ##[0:1] (host_master_valid || run_firmware)) else $error("irq released early");
    AST_DEFAULTS_RUN: assert property (cfg_defaults |=> run_firmware)
        else $error("no run after defaults");
    AST_RUN_CAUSE: assert property ($rose(run_firmware) |-> $past(cfg_defaults))
        else $error("run without defaults");
    AST_SPI_HELD: assert property (host_master_valid |=> $stable(host_if_spi))
        else $error("interface latch lost");
    cover property (run_firmware);
    cover property (host_if_spi && host_master_valid);
    cover property (!host_if_spi && host_master_valid);
endmodule // bcl_boot_loader_sva
bind bcl_boot_loader bcl_boot_loader_sva bcl_boot_loader_sva_i (.mclk(mclk), .rst_n(rst_n),
    .boot_straps(boot_straps), .supply_source_strap(supply_source_strap),
    .core_supply_good(core_supply_good), .swap_req(swap_req), .regulator_en(regulator_en),
    .pll_en(pll_en), .pll_src(pll_src), .host_interrupt_n(host_interrupt_n),
    .event_push(event_push), .host_if_spi(host_if_spi), .host_master_valid(host_master_valid),
    .flash_chip_select_oe(flash_chip_select_oe), .flash_sck_oe(flash_sck_oe),
    .flash_mosi_oe(flash_mosi_oe), .cfg_defaults(cfg_defaults), .run_firmware(run_firmware));
`default_nettype wire

/* File: test/tb_bcl_boot_loader.sv */
// self-checking bench for the boot code loader
// assumes the checker is bound in; short settle and image counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
`define WAITFOR(c) begin @(posedge mclk); for (int n = 0; n < 3000 && !(c); n++) \
    @(posedge mclk); if (!(c)) begin fails++; report_and_stop(); end end
module tb_bcl_boot_loader;
    localparam int SETTLE = 8;
    logic mclk = 1'b0, rst_n = 1'b0, supply_source_strap = 1'b0, core_supply_good = 1'b0;
    logic pll_locked = 1'b0, swap_req = 1'b0, swap_from_flash = 1'b0, host_clk = 1'b0;
    logic host_cs_n = 1'b1, host_sda_in = 1'b1, hrun = 1'b0;
    logic [2:0] boot_straps = 3'h0;
    wire regulator_en, pll_en, host_interrupt_n, event_push, host_if_spi, host_master_valid;
    wire flash_chip_select, flash_chip_select_oe, flash_sck, flash_sck_oe, flash_mosi;
    wire flash_mosi_oe, load_byte_valid, load_in_config, cfg_defaults, run_firmware;
    wire boot_timeout, flash_miso;
    wire [1:0] pll_src;
    wire [7:0] load_byte;
    wire [31:0] cmd_word;
    int fails = 0, checked = 0;
    always #2 mclk = ~mclk;
    // host clock 8 MHz, under the spi limit
    always #62.5 if (hrun) host_clk = ~host_clk;
    bcl_boot_loader #(.STRAP_SETTLE_CYC(32'h00000008), .BOOT_LIMIT_CYC(32'h00001388),
        .IMAGE_BYTES(24'h000004)) bcl_boot_loader_i (.*);
    bcl_flash_model bcl_flash_model_i (.sck(flash_sck_oe ? flash_sck : 1'b0),
        .cs_n(flash_chip_select_oe ? flash_chip_select : 1'b1), .mosi(flash_mosi),
        .miso(flash_miso), .cmd_word(cmd_word));
    task automatic report_and_stop;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // system clock already runs before release; host clock held low
    task automatic bring_up(input logic [2:0] st, input logic sup);
        rst_n <= 1'b0;
        boot_straps <= st;
        supply_source_strap <= sup;
        core_supply_good <= 1'b0;
        pll_locked <= 1'b0;
        host_clk <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        `CHK(flash_chip_select_oe, 1'b0)
        repeat (SETTLE + 4) @(posedge mclk);
        `CHK(regulator_en, ~sup)
        `CHK(pll_en, 1'b0)
        core_supply_good <= 1'b1;
        `WAITFOR(pll_en)
        `CHK(pll_src, (st[1:0] == 2'h3) ? 2'h0 : st[1:0])
        pll_locked <= 1'b1;
        `WAITFOR(event_push)
        @(posedge mclk);
        `CHK(host_interrupt_n, 1'b0)
    endtask
    task automatic flash_boot;
        bring_up(3'h5, 1'b0);
        `CHK(flash_chip_select_oe, 1'b1)
        for (int k = 0; k < 4; k++) begin
            `WAITFOR(load_byte_valid)
            `CHK(load_byte, 8'h3C + 8'h11 * k[7:0])
            `CHK(load_in_config, (k >= 2))
        end
        `CHK(cmd_word, 32'h03000000)
        `WAITFOR(cfg_defaults)
        @(posedge mclk);
        `CHK(run_firmware, 1'b1)
        `CHK(flash_chip_select, 1'b1)
        `CHK(boot_timeout, 1'b0)
        // swap from the running image to a host download
        swap_from_flash <= 1'b0;
        swap_req <= 1'b1;
        @(posedge mclk);
        swap_req <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(run_firmware, 1'b0)
        `CHK(host_interrupt_n, 1'b0)
    endtask
    task automatic host_spi;
        bring_up(3'h3, 1'b1);
        `CHK(flash_chip_select_oe, 1'b0)
        host_cs_n <= 1'b0;
        hrun = 1'b1;
        `WAITFOR(host_master_valid)
        hrun = 1'b0;
        host_cs_n <= 1'b1;
        `CHK(host_if_spi, 1'b1)
        @(posedge mclk);
        `CHK(host_interrupt_n, 1'b1)
        // an i2c start must not undo the latched choice
        host_clk <= 1'b1;
        repeat (4) @(posedge mclk);
        host_sda_in <= 1'b0;
        repeat (10) @(posedge mclk);
        `CHK(host_if_spi, 1'b1)
        host_sda_in <= 1'b1;
    endtask
    task automatic host_i2c_swap;
        bring_up(3'h2, 1'b0);
        host_clk <= 1'b1;
        repeat (4) @(posedge mclk);
        host_sda_in <= 1'b0;
        `WAITFOR(host_master_valid)
        `CHK(host_if_spi, 1'b0)
        host_sda_in <= 1'b1;
        host_clk <= 1'b0;
        swap_from_flash <= 1'b0; // swap by host download
        swap_req <= 1'b1;
        @(posedge mclk);
        swap_req <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(host_interrupt_n, 1'b0)
        `CHK(host_master_valid, 1'b0)
        host_cs_n <= 1'b0;
        hrun = 1'b1;
        `WAITFOR(host_if_spi)
        hrun = 1'b0;
        host_cs_n <= 1'b1;
        `CHK(host_if_spi, 1'b1)
        `CHK(flash_chip_select_oe, 1'b0)
        @(posedge mclk);
        `CHK(host_master_valid, 1'b1)
        // second swap, this time loading from flash
        swap_from_flash <= 1'b1;
        swap_req <= 1'b1;
        @(posedge mclk);
        swap_req <= 1'b0;
        `WAITFOR(cfg_defaults)
        @(posedge mclk);
        `CHK(run_firmware, 1'b1)
        `CHK(load_byte, 8'h6F)
        `CHK(cmd_word, 32'h03000000)
    endtask
    initial begin
        flash_boot();
        host_spi();
        host_i2c_swap();
        report_and_stop();
    end
endmodule // tb_bcl_boot_loader
`default_nettype wire
